/* core/alm_pkg.sv */
// Package for the axis limit monitor: register map, field positions, encodings.
// Assumes a 32-bit APB slave with word-aligned registers.
package alm_pkg;
   localparam int ALM_AW = 8;
   localparam logic [ALM_AW-1:0] ALM_REG_CTRL = 8'h00;
   localparam logic [ALM_AW-1:0] ALM_REG_LIMCFG = 8'h04;
   localparam logic [ALM_AW-1:0] ALM_REG_SOFT_LO = 8'h08;
   localparam logic [ALM_AW-1:0] ALM_REG_SOFT_HI = 8'h0C;
   localparam logic [ALM_AW-1:0] ALM_REG_TARGET = 8'h10;
   localparam logic [ALM_AW-1:0] ALM_REG_POSITION = 8'h14;
   localparam logic [ALM_AW-1:0] ALM_REG_STATUS = 8'h18;
   localparam logic [ALM_AW-1:0] ALM_REG_DIR = 8'h1C;
   // Control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_GINV_BIT = 1;
   localparam int CTRL_MODE_LSB = 4;
   // Limit configuration fields
   localparam int CFG_HARD_POS_BIT = 0;
   localparam int CFG_HARD_NEG_BIT = 1;
   localparam int CFG_HARD_ACT_LSB = 2;
   localparam int CFG_HARD_FLIP_BIT = 4;
   localparam int CFG_SOFT_HI_BIT = 8;
   localparam int CFG_SOFT_LO_BIT = 9;
   localparam int CFG_SOFT_ACT_LSB = 10;
   // Status fields
   localparam int ST_ERROR_BIT = 0;
   localparam int ST_POS_HARD_BIT = 1;
   localparam int ST_NEG_HARD_BIT = 2;
   localparam int ST_HI_SOFT_BIT = 3;
   localparam int ST_LO_SOFT_BIT = 4;
   localparam int ST_POS_IN_BIT = 5;
   localparam int ST_NEG_IN_BIT = 6;
   localparam int ST_HOME_BIT = 7;
   localparam int ST_ENABLED_BIT = 8;
   localparam int ST_STOP_LSB = 9;
   // Reset values
   localparam logic [31:0] ALM_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] ALM_LIMCFG_RST = 32'h0000_0000;
   localparam logic [31:0] ALM_POS_RST = 32'h0000_0000;
   // Setting both bound enables at once is the combined setting
   localparam logic [1:0] BOTH_BOUNDS_ENABLE = 2'b11;

   typedef enum logic [1:0] {
      ALM_MODE_POSITION = 2'b00,
      ALM_MODE_VELOCITY = 2'b01,
      ALM_MODE_CONTOUR = 2'b10,
      ALM_MODE_TORQUE = 2'b11
   } alm_mode_e;

   typedef enum logic [1:0] {
      ALM_STOP_NONE = 2'b00,
      ALM_STOP_POWER_DOWN = 2'b01,
      ALM_STOP_IMMEDIATE = 2'b10,
      ALM_STOP_DECELERATED = 2'b11
   } alm_stop_e;

   typedef enum logic [1:0] {
      ALM_ST_IDLE = 2'b00,
      ALM_ST_CHECK = 2'b01,
      ALM_ST_MOVING = 2'b10,
      ALM_ST_HALTED = 2'b11
   } alm_state_e;
endpackage : alm_pkg

/* core/alm_sync.sv */
// Two-flop synchroniser bank for sensor inputs.
// Assumes inputs are asynchronous to pclk.
module alm_sync
   import alm_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : alm_sync

/* core/alm_soft_cmp.sv */
// Signed comparison of a commanded target against the soft bounds.
// Assumes bounds and target are registered on pclk.
module alm_soft_cmp
   import alm_pkg::*;
#(
   parameter int PW = 32
) (
   input wire logic [PW-1:0] target,
   input wire logic [PW-1:0] bound_lo,
   input wire logic [PW-1:0] bound_hi,
   output logic above_hi,
   output logic below_lo
);
   always_comb begin
      above_hi = $signed(target) > $signed(bound_hi);
      below_lo = $signed(target) < $signed(bound_lo);
   end
endmodule : alm_soft_cmp

/* core/alm_axis_limit_monitor.sv */
// Axis limit monitor: hard and soft limit supervision for one axis, APB slave.
// Assumes synchronous APB master on pclk; sensor pins are asynchronous.
module alm_axis_limit_monitor
   import alm_pkg::*;
#(
   parameter int PW = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ALM_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pos_limit_in,
   input wire logic neg_limit_in,
   input wire logic home_in,
   input wire logic move_done,
   output logic axis_power_on,
   output logic stop_immediate,
   output logic stop_decelerated,
   output logic move_start,
   output logic [PW-1:0] move_target
);
   logic [2:0] pins_s;
   logic wr_en;
   logic rd_en;
   logic ctrl_wr;
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] cfg_q, cfg_d;
   logic [PW-1:0] soft_lo_q, soft_lo_d;
   logic [PW-1:0] soft_hi_q, soft_hi_d;
   logic [PW-1:0] target_q, target_d;
   logic [PW-1:0] pos_q, pos_d;
   logic dir_neg_q, dir_neg_d;
   logic err_q, err_d;
   logic ptrip_q, ptrip_d;
   logic ntrip_q, ntrip_d;
   logic htrip_q, htrip_d;
   logic ltrip_q, ltrip_d;
   logic [1:0] stop_q, stop_d;
   logic start_q, start_d;
   alm_state_e state_q, state_d;
   logic [31:0] rdata_d;
   logic pos_act, neg_act;
   logic above_hi, below_lo;
   logic hard_p, hard_n, soft_h, soft_l;
   alm_mode_e mode;
   logic enable_rise;

   function automatic logic reg_hit(input logic [ALM_AW-1:0] a, input logic [ALM_AW-1:0] r);
      reg_hit = (a == r);
   endfunction : reg_hit

   alm_sync #(.WIDTH(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({home_in, neg_limit_in, pos_limit_in}),
      .sync_out(pins_s)
   );

   alm_soft_cmp #(.PW(PW)) u_cmp (
      .target(target_q),
      .bound_lo(soft_lo_q),
      .bound_hi(soft_hi_q),
      .above_hi(above_hi),
      .below_lo(below_lo)
   );

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign mode = alm_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
   assign ctrl_wr = wr_en && reg_hit(paddr, ALM_REG_CTRL);
   assign enable_rise = ctrl_wr && pwdata[CTRL_ENABLE_BIT] && !ctrl_q[CTRL_ENABLE_BIT];

   // Active level: conducting isolator reads 1, optionally inverted globally or per axis
   always_comb begin
      pos_act = pins_s[0] ^ ctrl_q[CTRL_GINV_BIT] ^ cfg_q[CFG_HARD_FLIP_BIT];
      neg_act = pins_s[1] ^ ctrl_q[CTRL_GINV_BIT] ^ cfg_q[CFG_HARD_FLIP_BIT];
   end

   // Hard-limit trip conditions by mode and direction
   always_comb begin
      hard_p = 1'b0;
      hard_n = 1'b0;
      case (mode)
         ALM_MODE_POSITION, ALM_MODE_VELOCITY: begin
            hard_p = pos_act && cfg_q[CFG_HARD_POS_BIT] && !dir_neg_q;
            hard_n = neg_act && cfg_q[CFG_HARD_NEG_BIT] && dir_neg_q;
         end
         ALM_MODE_CONTOUR: begin
            hard_p = pos_act && cfg_q[CFG_HARD_POS_BIT];
            hard_n = neg_act && cfg_q[CFG_HARD_NEG_BIT];
         end
         ALM_MODE_TORQUE: begin
            hard_p = 1'b0;
            hard_n = 1'b0;
         end
         default: begin
            hard_p = 1'b0;
            hard_n = 1'b0;
         end
      endcase
      if (state_q != ALM_ST_MOVING || !ctrl_q[CTRL_ENABLE_BIT]) begin
         hard_p = 1'b0;
         hard_n = 1'b0;
      end
      soft_h = (state_q == ALM_ST_CHECK) && cfg_q[CFG_SOFT_HI_BIT] && above_hi;
      soft_l = (state_q == ALM_ST_CHECK) && cfg_q[CFG_SOFT_LO_BIT] && below_lo;
   end

   // Register file writes
   always_comb begin
      ctrl_d = ctrl_q;
      cfg_d = cfg_q;
      soft_lo_d = soft_lo_q;
      soft_hi_d = soft_hi_q;
      target_d = target_q;
      pos_d = pos_q;
      dir_neg_d = dir_neg_q;
      if (wr_en) begin
         case (paddr)
            ALM_REG_CTRL: ctrl_d = pwdata;
            ALM_REG_LIMCFG: cfg_d = pwdata;
            ALM_REG_SOFT_LO: soft_lo_d = pwdata[PW-1:0];
            ALM_REG_SOFT_HI: soft_hi_d = pwdata[PW-1:0];
            ALM_REG_TARGET: target_d = pwdata[PW-1:0];
            ALM_REG_POSITION: pos_d = pwdata[PW-1:0];
            ALM_REG_DIR: dir_neg_d = pwdata[0];
            default: ;
         endcase
      end
      if (state_q == ALM_ST_MOVING && move_done) begin
         pos_d = target_q;
      end
   end

   // Motion sequencing: target write starts check, then motion
   always_comb begin
      state_d = state_q;
      start_d = 1'b0;
      stop_d = stop_q;
      err_d = err_q;
      ptrip_d = ptrip_q;
      ntrip_d = ntrip_q;
      htrip_d = htrip_q;
      ltrip_d = ltrip_q;
      if (enable_rise) begin
         err_d = 1'b0;
         ptrip_d = 1'b0;
         ntrip_d = 1'b0;
         htrip_d = 1'b0;
         ltrip_d = 1'b0;
         stop_d = ALM_STOP_NONE;
         state_d = ALM_ST_IDLE;
      end
      case (state_q)
         ALM_ST_IDLE: begin
            if (wr_en && reg_hit(paddr, ALM_REG_TARGET) && ctrl_q[CTRL_ENABLE_BIT]) begin
               state_d = ALM_ST_CHECK;
            end
         end
         ALM_ST_CHECK: begin
            if (soft_h || soft_l) begin
               err_d = 1'b1;
               htrip_d = htrip_q || soft_h;
               ltrip_d = ltrip_q || soft_l;
               stop_d = cfg_q[CFG_SOFT_ACT_LSB +: 2];
               state_d = ALM_ST_HALTED;
            end else begin
               start_d = 1'b1;
               state_d = ALM_ST_MOVING;
            end
         end
         ALM_ST_MOVING: begin
            if (hard_p || hard_n) begin
               err_d = 1'b1;
               ptrip_d = ptrip_q || hard_p;
               ntrip_d = ntrip_q || hard_n;
               stop_d = cfg_q[CFG_HARD_ACT_LSB +: 2];
               state_d = ALM_ST_HALTED;
            end else if (move_done) begin
               state_d = ALM_ST_IDLE;
            end
         end
         ALM_ST_HALTED: begin
            if (enable_rise) begin
               state_d = ALM_ST_IDLE;
            end
         end
         default: state_d = ALM_ST_IDLE;
      endcase
      if (!ctrl_q[CTRL_ENABLE_BIT] && state_q != ALM_ST_HALTED) begin
         state_d = ALM_ST_IDLE;
      end
   end

   // Read mux, data registered in the setup phase
   always_comb begin
      rdata_d = prdata;
      if (rd_en) begin
         rdata_d = 32'h0000_0000;
         case (paddr)
            ALM_REG_CTRL: rdata_d = ctrl_q;
            ALM_REG_LIMCFG: rdata_d = cfg_q;
            ALM_REG_SOFT_LO: rdata_d = 32'(soft_lo_q);
            ALM_REG_SOFT_HI: rdata_d = 32'(soft_hi_q);
            ALM_REG_TARGET: rdata_d = 32'(target_q);
            ALM_REG_POSITION: rdata_d = 32'(pos_q);
            ALM_REG_DIR: rdata_d = {31'h0000_0000, dir_neg_q};
            ALM_REG_STATUS: begin
               rdata_d[ST_ERROR_BIT] = err_q;
               rdata_d[ST_POS_HARD_BIT] = ptrip_q;
               rdata_d[ST_NEG_HARD_BIT] = ntrip_q;
               rdata_d[ST_HI_SOFT_BIT] = htrip_q;
               rdata_d[ST_LO_SOFT_BIT] = ltrip_q;
               rdata_d[ST_POS_IN_BIT] = pos_act;
               rdata_d[ST_NEG_IN_BIT] = neg_act;
               rdata_d[ST_HOME_BIT] = pins_s[2] ^ ctrl_q[CTRL_GINV_BIT];
               rdata_d[ST_ENABLED_BIT] = ctrl_q[CTRL_ENABLE_BIT];
               rdata_d[ST_STOP_LSB +: 2] = stop_q;
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= ALM_CTRL_RST;
         cfg_q <= ALM_LIMCFG_RST;
         soft_lo_q <= '0;
         soft_hi_q <= '0;
         target_q <= '0;
         pos_q <= '0;
         dir_neg_q <= 1'b0;
         err_q <= 1'b0;
         ptrip_q <= 1'b0;
         ntrip_q <= 1'b0;
         htrip_q <= 1'b0;
         ltrip_q <= 1'b0;
         stop_q <= ALM_STOP_NONE;
         start_q <= 1'b0;
         state_q <= ALM_ST_IDLE;
         prdata <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         cfg_q <= cfg_d;
         soft_lo_q <= soft_lo_d;
         soft_hi_q <= soft_hi_d;
         target_q <= target_d;
         pos_q <= pos_d;
         dir_neg_q <= dir_neg_d;
         err_q <= err_d;
         ptrip_q <= ptrip_d;
         ntrip_q <= ntrip_d;
         htrip_q <= htrip_d;
         ltrip_q <= ltrip_d;
         stop_q <= stop_d;
         start_q <= start_d;
         state_q <= state_d;
         prdata <= rdata_d;
      end
   end

   assign pslverr = 1'b0;
   assign axis_power_on = ctrl_q[CTRL_ENABLE_BIT] && (stop_q != ALM_STOP_POWER_DOWN);
   assign stop_immediate = (stop_q == ALM_STOP_IMMEDIATE);
   assign stop_decelerated = (stop_q == ALM_STOP_DECELERATED);
   assign move_start = start_q;
   assign move_target = target_q;

   property p_hard_trip_sets_flags;
      @(posedge pclk) disable iff (!presetn)
      (hard_p && !enable_rise) |=> (err_q && ptrip_q && state_q == ALM_ST_HALTED);
   endproperty
   a_hard_trip_sets_flags: assert property (p_hard_trip_sets_flags) else $error("hard trip not flagged");

   property p_torque_ignores;
      @(posedge pclk) disable iff (!presetn)
      (mode == ALM_MODE_TORQUE && state_q == ALM_ST_MOVING) |=> (state_q != ALM_ST_HALTED);
   endproperty
   a_torque_ignores: assert property (p_torque_ignores) else $error("torque mode tripped");

   property p_direction_sensitive;
      @(posedge pclk) disable iff (!presetn)
      (mode == ALM_MODE_POSITION && dir_neg_q) |-> !hard_p;
   endproperty
   a_direction_sensitive: assert property (p_direction_sensitive) else $error("wrong direction trip");

   property p_flags_sticky;
      @(posedge pclk) disable iff (!presetn)
      (err_q && !enable_rise) |=> err_q;
   endproperty
   a_flags_sticky: assert property (p_flags_sticky) else $error("error flag lost");

   property p_soft_trip;
      @(posedge pclk) disable iff (!presetn)
      (soft_h && !enable_rise) |=> (htrip_q && err_q && !move_start);
   endproperty
   a_soft_trip: assert property (p_soft_trip) else $error("soft trip not flagged");

   property p_stop_action;
      @(posedge pclk) disable iff (!presetn)
      ((hard_p || hard_n) && !enable_rise) |=> (stop_q == $past(cfg_q[CFG_HARD_ACT_LSB +: 2]));
   endproperty
   a_stop_action: assert property (p_stop_action) else $error("wrong stop action");

   property p_pos_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ALM_REG_POSITION && !(state_q == ALM_ST_MOVING && move_done)) |=> (pos_q == $past(pwdata));
   endproperty
   a_pos_write: assert property (p_pos_write) else $error("position write lost");

   property p_contour_any_dir;
      @(posedge pclk) disable iff (!presetn)
      (mode == ALM_MODE_CONTOUR && state_q == ALM_ST_MOVING && ctrl_q[CTRL_ENABLE_BIT]
       && pos_act && cfg_q[CFG_HARD_POS_BIT]) |-> hard_p;
   endproperty
   a_contour_any_dir: assert property (p_contour_any_dir) else $error("contour trip missed");
endmodule : alm_axis_limit_monitor

/* bench/alm_sensor_model.sv */
// Model of the opto-isolated limit and home sensors at the axis pins.
// Assumes the bench sets each switch state; the isolator output lags it, unrelated to pclk.
module alm_sensor_model (
   input wire logic pos_on,
   input wire logic neg_on,
   input wire logic home_on,
   output wire logic pos_limit_in,
   output wire logic neg_limit_in,
   output wire logic home_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // High while the isolator conducts
   assign #1.3 pos_limit_in = pos_on;
   assign #1.7 neg_limit_in = neg_on;
   assign #2.1 home_in = home_on;
endmodule : alm_sensor_model

/* bench/axis_limit_monitor_tb.sv */
// Self-checking bench for the axis limit monitor, with an integer model of the expected results.
// Assumes the APB slave and the sensor model; clock 200 MHz.
module axis_limit_monitor_tb
   import alm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, pos_on, neg_on, home_on, move_done;
   logic [ALM_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, move_target, r, tgt;
   logic pos_limit_in, neg_limit_in, home_in, axis_power_on, stop_immediate, stop_decelerated, move_start;
   logic got, trip, hi, lo, inv;
   int bad_count = 0;
   int n_tests = 0;
   int act, pol, tv[7], ev[7];

   always #2.5 pclk = ~pclk;

   alm_axis_limit_monitor #(.PW(32)) u_alm_axis_limit_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pos_limit_in(pos_limit_in), .neg_limit_in(neg_limit_in), .home_in(home_in),
      .move_done(move_done), .axis_power_on(axis_power_on), .stop_immediate(stop_immediate),
      .stop_decelerated(stop_decelerated), .move_start(move_start), .move_target(move_target));

   alm_sensor_model u_alm_sensor_model (.pos_on(pos_on), .neg_on(neg_on), .home_on(home_on),
      .pos_limit_in(pos_limit_in), .neg_limit_in(neg_limit_in), .home_in(home_in));

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // One APB transfer: setup, then access until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 32);
      if (pready !== 1'b1) begin
         check("pready", pready, 1'b1);
         final_report();
      end
      rd = prdata;
      check("pslverr", pslverr, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      apb(1'b1, a, d, dummy);
   endtask : wr

   // Waits a bounded time for the start pulse; absence is a result, not a hang
   task wait_start(output logic g, output logic [31:0] t);
      g = 1'b0;
      t = '0;
      for (int i = 0; i < 12 && !g; i++) begin
         @(posedge pclk);
         if (move_start === 1'b1) begin
            g = 1'b1;
            t = move_target;
         end
      end
   endtask : wait_start

   task finish_move;
      move_done <= 1'b1;
      @(posedge pclk);
      move_done <= 1'b0;
   endtask : finish_move

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, move_done} = 4'h0;
      {pos_on, neg_on, home_on} = 3'h0;
      paddr = '0;
      pwdata = '0;
      void'($urandom(65));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      pos_on <= 1'b1;
      neg_on <= 1'b1;
      home_on <= 1'b1;
      apb(1'b0, ALM_REG_CTRL, 0, r);
      check("ctrl_rst", r, ALM_CTRL_RST);
      apb(1'b0, ALM_REG_LIMCFG, 0, r);
      check("limcfg_rst", r, ALM_LIMCFG_RST);
      apb(1'b0, ALM_REG_POSITION, 0, r);
      check("pos_rst", r, ALM_POS_RST);
      wr(8'h20, 32'hFFFF_FFFF);
      apb(1'b0, 8'h20, 0, r);
      check("unmapped", r, 32'h0000_0000);
      tgt = $urandom;
      wr(ALM_REG_POSITION, tgt);
      apb(1'b0, ALM_REG_POSITION, 0, r);
      check("pos_write", r, tgt);
      apb(1'b0, ALM_REG_STATUS, 0, r);
      check("inputs_on", r[7:5], 3'h7);
      wr(ALM_REG_CTRL, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      apb(1'b0, ALM_REG_STATUS, 0, r);
      check("inputs_inv", r[7:5], 3'h0);
      wr(ALM_REG_CTRL, 32'h0000_0000);
      {pos_on, neg_on, home_on} <= 3'h0;
      $display("test registers done");

      wr(ALM_REG_SOFT_LO, 32'hFFFF_FF9C);
      wr(ALM_REG_SOFT_HI, 32'h0000_01EA);
      tv = '{500, -200, 490, -100, 491, -101, -200};
      ev = '{3, 3, 3, 3, 1, 2, 1};
      foreach (tv[i]) begin
         act = 1 + $urandom % 3;
         wr(ALM_REG_CTRL, 32'h0000_0000);
         wr(ALM_REG_LIMCFG, (ev[i] << CFG_SOFT_HI_BIT) | (act << CFG_SOFT_ACT_LSB));
         wr(ALM_REG_CTRL, 32'h0000_0001);
         wr(ALM_REG_TARGET, tv[i]);
         wait_start(got, tgt);
         hi = ev[i][0] && tv[i] > 490;
         lo = ev[i][1] && tv[i] < -100;
         trip = hi | lo;
         check("soft_start", got, !trip);
         if (got) check("soft_target", tgt, tv[i]);
         apb(1'b0, ALM_REG_STATUS, 0, r);
         check("soft_flags", r[4:0], {lo, hi, 2'b00, trip});
         check("soft_stop", r[10:9], trip ? act : 0);
         check("soft_power", axis_power_on, !(trip && act == 1));
         if (!trip) finish_move();
         wr(ALM_REG_CTRL, 32'h0000_0000);
         apb(1'b0, ALM_REG_STATUS, 0, r);
         check("soft_sticky", r[0], trip);
      end
      $display("test soft bounds done");

      for (int m = 0; m < 4; m++) for (int d = 0; d < 2; d++) for (int s = 0; s < 2; s++)
         for (int e = 1; e < 4; e++) begin
            pol = $urandom % 3;
            act = 1 + $urandom % 3;
            inv = pol != 0;
            pos_on <= inv;
            neg_on <= inv;
            repeat (4) @(posedge pclk);
            wr(ALM_REG_CTRL, 32'h0000_0000);
            wr(ALM_REG_LIMCFG, e | (act << CFG_HARD_ACT_LSB) | ((pol == 2) << CFG_HARD_FLIP_BIT));
            wr(ALM_REG_DIR, d);
            wr(ALM_REG_CTRL, (m << CTRL_MODE_LSB) | ((pol == 1) << CTRL_GINV_BIT) | 1);
            wr(ALM_REG_TARGET, $urandom % 1000);
            wait_start(got, tgt);
            check("hard_start", got, 1'b1);
            if (s == 0) pos_on <= !inv;
            else neg_on <= !inv;
            repeat (6) @(posedge pclk);
            trip = e[s] && (m == 2 || (m < 2 && d == s));
            apb(1'b0, ALM_REG_STATUS, 0, r);
            check("hard_flags", r[2:0], {s == 1 && trip, s == 0 && trip, trip});
            check("hard_stop", r[10:9], trip ? act : 0);
            check("hard_outs", {axis_power_on, stop_immediate, stop_decelerated},
               {!(trip && act == 1), trip && act == 2, trip && act == 3});
            check("live_in", r[6:5], s ? 2'b10 : 2'b01);
            pos_on <= inv;
            neg_on <= inv;
            finish_move();
         end
      $display("test hard limits done");

      // Reset in mid-run must zero the position and the sticky flags
      wr(ALM_REG_POSITION, 32'h0000_1234);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ALM_REG_POSITION, 0, r);
      check("pos_rerst", r, ALM_POS_RST);
      apb(1'b0, ALM_REG_STATUS, 0, r);
      check("flags_rerst", r[4:0], 5'h00);
      $display("test reset done");
      final_report();
   end
endmodule : axis_limit_monitor_tb
